// file: rtl/ctm_cache_bank.sv
// one cache's tag array, data array and victim pointers
`timescale 1ns/100ps
module ctm_cache_bank
   import ctm_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic inv_all,
   input wire logic inv_one,
   input wire logic [CTM_ENT_W-1:0] one_ent,
   input wire logic dirty_all,
   input wire logic tag_wr,
   input wire ctm_tag_t tag_wdata,
   input wire logic ram_wr,
   input wire logic [CTM_RAM_W-1:0] ram_addr,
   input wire logic [31:0] ram_wdata,
   input wire logic base_wr,
   input wire logic vict_wr,
   input wire logic [CTM_SEG_W-1:0] vict_seg,
   input wire logic [CTM_IDX_W-1:0] vict_val,
   input wire logic tag_acc,
   input wire logic ram_acc,
   input wire logic [CTM_SEG_W-1:0] acc_seg,
   input wire logic [CTM_ENT_W-1:0] rd_ent,
   output ctm_tag_t tag_rdata,
   output logic [31:0] ram_rdata,
   output logic [CTM_IDX_W-1:0] base,
   output logic [CTM_IDX_W-1:0] vict_of_seg
);
   typedef struct packed {
      ctm_tag_t [CTM_ENT-1:0] tags;
      logic [CTM_ENT*CTM_LINE_WORDS-1:0][31:0] ram;
      logic [CTM_SEGS-1:0][CTM_IDX_W-1:0] vict;
      logic [CTM_IDX_W-1:0] base;
      logic ram_inc;
   } ctm_bank_t;

   ctm_bank_t s_reg;
   ctm_bank_t s_next;

   assign tag_rdata = s_reg.tags[rd_ent];
   assign ram_rdata = s_reg.ram[ram_addr];
   assign base = s_reg.base;
   assign vict_of_seg = s_reg.vict[acc_seg];

   always_comb begin
      s_next = s_reg;
      if (inv_all) begin
         for (int e = 0; e < CTM_ENT; e++) begin
            s_next.tags[e].valid = 1'b0; // [RULE3]
         end
      end
      if (inv_one) begin
         s_next.tags[one_ent].valid = 1'b0; // [RULE4] [RULE6]
      end
      if (dirty_all) begin
         for (int e = 0; e < CTM_ENT; e++) begin
            s_next.tags[e].dirty_even = 1'b1; // [RULE11]
            s_next.tags[e].dirty_odd = 1'b1;
         end
      end
      if (tag_wr) begin
         s_next.tags[rd_ent] = tag_wdata; // [RULE12]
      end
      if (ram_wr) begin
         s_next.ram[ram_addr] = ram_wdata; // [RULE13]
      end
      // pointer steps after the access that used it
      if (tag_acc || (ram_acc && s_reg.ram_inc)) begin
         s_next.vict[acc_seg] = s_reg.vict[acc_seg] + 1'b1; // [RULE22]
      end
      if (base_wr) begin
         s_next.base = vict_val; // [RULE9]
         s_next.ram_inc = 1'b1; // [RULE22]
         for (int g = 0; g < CTM_SEGS; g++) begin
            s_next.vict[g] = vict_val;
         end
      end else if (vict_wr) begin
         s_next.vict[vict_seg] = vict_val; // [RULE10]
         s_next.ram_inc = 1'b0; // [RULE22]
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// file: rtl/ctm_maint.sv
// coprocessor decode for cache maintenance and cache test operations
`timescale 1ns/100ps
// Overview of operation
// RULE1 - register 7 operations are write only
// RULE2 - register 9 supports read and write
// RULE3 - c7 crm 7/5/6 op2 0 invalidates cache
// RULE4 - invalidate single entry by address
// RULE5 - clean one data entry, address or index
// RULE6 - clean then invalidate one data entry
// RULE7 - prefetch instruction line by address
// RULE8 - read lockdown base of selected cache
// RULE9 - write base and every segment victim
// RULE10 - write victim of one named segment
// RULE11 - set dirty on all entries
// RULE12 - tag array read and write tests
// RULE13 - data array word read and write
// RULE14 - tag match reports hit and data
// RULE15 - match does no lookup nor linefill
// RULE16 - test ops are writes, rd is address
// RULE17 - two readable writable test data registers
// RULE18 - one op may act on both caches
// RULE19 - debug interpret path reaches every op
// RULE20 - drain write buffer stalls execution
// RULE21 - wait for interrupt stops until interrupt
// RULE22 - victim pointer indexes and auto increments
module ctm_maint
   import ctm_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire ctm_req_t req,
   input wire logic dbg_interp,
   input wire ctm_req_t dbg_req,
   input wire logic dbg_valid,
   input wire logic wb_empty,
   input wire logic irq,
   input wire logic clean_done,
   output logic busy,
   output logic rdata_valid,
   output logic [31:0] rdata,
   output logic undef,
   output logic clean_req,
   output logic [31:0] clean_addr,
   output logic clean_by_index,
   output logic prefetch_req,
   output logic [31:0] prefetch_addr,
   output logic low_power
);
   typedef struct packed {
      ctm_state_t st;
      logic [31:0] tdr_i;
      logic [31:0] tdr_d;
      logic busy;
      logic rv;
      logic [31:0] rdata;
      logic undef;
      logic clean_req;
      logic [31:0] clean_addr;
      logic clean_idx;
      logic inv_after;
      logic pf_req;
      logic [31:0] pf_addr;
      logic lp;
      logic [1:0] sync_wb;
      logic [1:0] sync_irq;
   } ctm_top_t;

   ctm_top_t s_reg;
   ctm_top_t s_next;

   // debug interpret mode presents the same instruction form
   ctm_req_t q;
   logic qv;
   always_comb begin
      q = dbg_interp ? dbg_req : req; // [RULE19]
      qv = dbg_interp ? dbg_valid : req_valid;
   end

   logic is7, is9, is15, is_tdr, is_test;
   logic [CTM_SEG_W-1:0] seg;
   logic [CTM_WORD_W-1:0] word;
   logic [CTM_IDX_W-1:0] idx;
   logic [CTM_TAG_W-1:0] rd_tag;
   logic go;
   assign go = qv && (s_reg.st == CTM_S_IDLE);
   assign is7 = go && q.op1 == CTM_OP1_STD && q.crn == CTM_CRN_CACHE;
   assign is9 = go && q.op1 == CTM_OP1_STD && q.crn == CTM_CRN_LOCK;
   assign is15 = go && q.crn == CTM_CRN_TEST;
   assign is_test = is15 && q.op1 == CTM_OP1_TEST && q.wr;
   assign is_tdr = is15 && q.op1 == CTM_OP1_TDR;
   assign seg = q.rd[CTM_RD_SEG_LSB +: CTM_SEG_W];
   assign word = q.rd[CTM_RD_WORD_LSB +: CTM_WORD_W];
   assign idx = q.rd[CTM_RD_IDX_LSB +: CTM_IDX_W];
   assign rd_tag = q.rd[CTM_RD_TAG_LSB +: CTM_TAG_W];

   // per-cache controls: index 0 instruction, 1 data
   logic [1:0] inv_all, inv_one, dirty_all, tag_wr, ram_wr;
   logic [1:0] base_wr, vict_wr, tag_acc, ram_acc, tag_rd, ram_rd;
   logic [1:0] match_rd;
   logic [1:0] sel;
   ctm_tag_t tag_rdata [2];
   logic [31:0] ram_rdata [2];
   logic [CTM_IDX_W-1:0] base [2];
   logic [CTM_IDX_W-1:0] vict [2];
   logic [CTM_ENT_W-1:0] ent [2];
   logic [CTM_ENT_W-1:0] mva_ent;
   ctm_tag_t tag_wdata;
   logic [1:0] hit;

   assign mva_ent = {seg, q.rd[CTM_RD_IDX_LSB +: CTM_IDX_W]};

   always_comb begin
      tag_wdata = '0;
      tag_wdata.valid = q.rd[CTM_RD_VLD_BIT];
      tag_wdata.tag = rd_tag;
      tag_wdata.dirty_even = q.rd[CTM_RD_DE_BIT];
      tag_wdata.dirty_odd = q.rd[CTM_RD_DO_BIT];
      tag_wdata.wb = q.rd[CTM_RD_WB_BIT];
   end

   // crm low bits choose instruction, data or both caches
   always_comb begin
      unique case (q.crm)
         CTM_CRM_1, CTM_CRM_I, CTM_CRM_RI: sel = 2'h1;
         CTM_CRM_2, CTM_CRM_D, CTM_CRM_RD: sel = 2'h2;
         CTM_CRM_3, CTM_CRM_ID, CTM_CRM_RID: sel = 2'h3; // [RULE18]
         default: sel = 2'h0;
      endcase
   end

   always_comb begin
      inv_all = '0;
      inv_one = '0;
      dirty_all = '0;
      tag_wr = '0;
      ram_wr = '0;
      base_wr = '0;
      vict_wr = '0;
      tag_rd = '0;
      ram_rd = '0;
      match_rd = '0;
      if (is7 && q.wr && q.op2 == CTM_OP2_0) begin
         unique case (q.crm)
            CTM_CRM_ID: inv_all = 2'h3; // [RULE3]
            CTM_CRM_I: inv_all = 2'h1;
            CTM_CRM_D: inv_all = 2'h2;
            default: inv_all = 2'h0;
         endcase
      end
      if (is7 && q.wr && q.op2 == CTM_OP2_1) begin
         if (q.crm == CTM_CRM_I) inv_one = 2'h1; // [RULE4]
         if (q.crm == CTM_CRM_D) inv_one = 2'h2;
      end
      if (is9 && q.wr && q.op2 <= CTM_OP2_1) begin
         if (q.crm == CTM_CRM_0) base_wr[~q.op2[0]] = 1'b1; // [RULE9]
         if (q.crm == CTM_CRM_1) vict_wr[~q.op2[0]] = 1'b1; // [RULE10]
      end
      if (is_test && q.op2 == CTM_OP2_0 && q.crm <= CTM_CRM_3) begin
         dirty_all = sel; // [RULE11]
      end
      if (is_test) begin // [RULE16]
         if (q.crm >= CTM_CRM_I && q.crm <= CTM_CRM_ID) begin
            if (q.op2 == CTM_OP2_2) tag_rd = sel; // [RULE12]
            if (q.op2 == CTM_OP2_WR) tag_wr = sel;
            if (q.op2 == CTM_OP2_MATCH) match_rd = sel; // [RULE14]
         end
         if (q.crm >= CTM_CRM_RI && q.crm <= CTM_CRM_RID) begin
            if (q.op2 == CTM_OP2_2) ram_rd = sel; // [RULE13]
            if (q.op2 == CTM_OP2_WR) ram_wr = sel;
         end
      end
      tag_acc = tag_rd | tag_wr; // [RULE22]
      ram_acc = ram_rd | ram_wr;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_bank
         logic [CTM_RAM_W-1:0] ram_addr;
         logic [CTM_ENT_W-1:0] sel_ent;
         // match reads use the tag row of the victim, no mmu lookup
         assign ent[gi] = {seg, vict[gi]}; // [RULE22]
         assign sel_ent = inv_one[gi] ? mva_ent : ent[gi];
         assign ram_addr = {ent[gi], word};
         assign hit[gi] = tag_rdata[gi].valid &&
            tag_rdata[gi].tag == rd_tag; // [RULE15]
         ctm_cache_bank u_bank (
            .clk(clk),
            .resetn(resetn),
            .inv_all(inv_all[gi]),
            .inv_one(inv_one[gi] | (s_reg.inv_after && clean_done &&
               gi == 1)),
            .one_ent(inv_one[gi] ? mva_ent :
               s_reg.clean_addr[CTM_RD_SEG_LSB +: CTM_ENT_W]),
            .dirty_all(dirty_all[gi]),
            .tag_wr(tag_wr[gi]),
            .tag_wdata(tag_wdata),
            .ram_wr(ram_wr[gi]),
            .ram_addr(ram_addr),
            .ram_wdata(gi == 0 ? s_reg.tdr_i : s_reg.tdr_d),
            .base_wr(base_wr[gi]),
            .vict_wr(vict_wr[gi]),
            .vict_seg(seg),
            .vict_val(idx),
            .tag_acc(tag_acc[gi]),
            .ram_acc(ram_acc[gi]),
            .acc_seg(seg),
            .rd_ent(sel_ent),
            .tag_rdata(tag_rdata[gi]),
            .ram_rdata(ram_rdata[gi]),
            .base(base[gi]),
            .vict_of_seg(vict[gi])
         );
      end
   endgenerate

   function automatic logic [31:0] tag_word(input ctm_tag_t t,
                                            input logic [5:0] v);
      logic [31:0] w;
      w = '0;
      w[CTM_RD_TAG_LSB +: CTM_TAG_W] = t.tag;
      w[CTM_RD_VLD_BIT] = t.valid;
      w[CTM_RD_DE_BIT] = t.dirty_even;
      w[CTM_RD_DO_BIT] = t.dirty_odd;
      w[CTM_RD_WB_BIT] = t.wb;
      // index bit 0 shares the word; the segment field is not needed
      w[0] = v[0];
      return w;
   endfunction

   always_comb begin
      s_next = s_reg;
      s_next.rv = 1'b0;
      s_next.undef = 1'b0;
      s_next.pf_req = 1'b0;
      s_next.sync_wb = {s_reg.sync_wb[0], wb_empty};
      s_next.sync_irq = {s_reg.sync_irq[0], irq};
      if (is7 && !q.wr) begin
         s_next.undef = 1'b1; // [RULE1]
      end
      if (is7 && q.wr && (q.crm == CTM_CRM_RD) &&
          (q.op2 == CTM_OP2_1 || q.op2 == CTM_OP2_2)) begin
         s_next.st = CTM_S_CLEAN; // [RULE5]
         s_next.clean_req = 1'b1;
         s_next.clean_addr = q.rd;
         s_next.clean_idx = (q.op2 == CTM_OP2_2);
         s_next.inv_after = 1'b0;
      end
      if (is7 && q.wr && q.crm == CTM_CRM_CLINV &&
          (q.op2 == CTM_OP2_1 || q.op2 == CTM_OP2_2)) begin
         s_next.st = CTM_S_CLEAN; // [RULE6]
         s_next.clean_req = 1'b1;
         s_next.clean_addr = q.rd;
         s_next.clean_idx = (q.op2 == CTM_OP2_2);
         s_next.inv_after = 1'b1;
      end
      if (is7 && q.wr && q.crm == CTM_CRM_PREF && q.op2 == CTM_OP2_1) begin
         s_next.pf_req = 1'b1; // [RULE7]
         s_next.pf_addr = q.rd;
      end
      if (is7 && q.wr && q.crm == CTM_CRM_RD && q.op2 == CTM_OP2_4)
      begin
         s_next.st = CTM_S_DRAIN; // [RULE20]
      end
      if (is7 && q.wr && q.crm == CTM_CRM_0 && q.op2 == CTM_OP2_4) begin
         s_next.st = CTM_S_WFI; // [RULE21]
         s_next.lp = 1'b1;
      end
      if (is9 && !q.wr && q.crm == CTM_CRM_0 && q.op2 <= CTM_OP2_1) begin
         s_next.rv = 1'b1; // [RULE2] [RULE8]
         s_next.rdata = '0;
         s_next.rdata[CTM_RD_IDX_LSB +: CTM_IDX_W] = base[~q.op2[0]];
      end
      for (int c = 0; c < 2; c++) begin
         logic [31:0] cap;
         logic take;
         cap = '0;
         take = 1'b0;
         if (tag_rd[c]) begin
            cap = tag_word(tag_rdata[c], vict[c]); // [RULE12]
            take = 1'b1;
         end
         if (ram_rd[c]) begin
            cap = ram_rdata[c]; // [RULE13]
            take = 1'b1;
         end
         if (match_rd[c]) begin
            cap = hit[c] ? ram_rdata[c] : '0; // [RULE14]
            take = 1'b1;
         end
         if (take && c == 0) s_next.tdr_i = cap;
         if (take && c == 1) s_next.tdr_d = cap;
      end
      if (is_tdr && q.wr && q.op2 == CTM_OP2_0) begin
         if (sel[0]) s_next.tdr_i = q.rd; // [RULE17] [RULE18]
         if (sel[1]) s_next.tdr_d = q.rd;
      end
      if (is_tdr && !q.wr && q.op2 == CTM_OP2_0 && sel != 2'h3) begin
         s_next.rv = 1'b1; // [RULE17]
         s_next.rdata = sel[0] ? s_reg.tdr_i : s_reg.tdr_d;
      end
      unique case (s_reg.st)
         CTM_S_IDLE: begin
         end
         CTM_S_CLEAN: begin
            if (clean_done) begin
               s_next.st = CTM_S_IDLE;
               s_next.clean_req = 1'b0;
            end
         end
         CTM_S_DRAIN: begin
            if (s_reg.sync_wb[1]) s_next.st = CTM_S_IDLE; // [RULE20]
         end
         CTM_S_WFI: begin
            if (s_reg.sync_irq[1]) begin
               s_next.st = CTM_S_IDLE; // [RULE21]
               s_next.lp = 1'b0;
            end
         end
      endcase
      s_next.busy = (s_next.st != CTM_S_IDLE);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign busy = s_reg.busy;
   assign rdata_valid = s_reg.rv;
   assign rdata = s_reg.rdata;
   assign undef = s_reg.undef;
   assign clean_req = s_reg.clean_req;
   assign clean_addr = s_reg.clean_addr;
   assign clean_by_index = s_reg.clean_idx;
   assign prefetch_req = s_reg.pf_req;
   assign prefetch_addr = s_reg.pf_addr;
   assign low_power = s_reg.lp;
endmodule

// file: rtl/ctm_pkg.sv
// package: coprocessor op encodings, field layouts and struct types
package ctm_pkg;
   localparam int CTM_SEGS = 8;
   localparam int CTM_IDX_W = 6;
   localparam int CTM_SEG_W = 3;
   localparam int CTM_WORD_W = 3;
   localparam int CTM_TAG_W = 24;
   localparam int CTM_LINES = 64;
   localparam int CTM_ENT = CTM_SEGS * CTM_LINES;
   localparam int CTM_ENT_W = 9;
   localparam int CTM_LINE_WORDS = 8;
   localparam int CTM_RAM_W = CTM_ENT_W + CTM_WORD_W;
   // rd field positions
   localparam int CTM_RD_IDX_LSB = 26;
   localparam int CTM_RD_SEG_LSB = 5;
   localparam int CTM_RD_WORD_LSB = 2;
   localparam int CTM_RD_TAG_LSB = 8;
   localparam int CTM_RD_VLD_BIT = 4;
   localparam int CTM_RD_DE_BIT = 3;
   localparam int CTM_RD_DO_BIT = 2;
   localparam int CTM_RD_WB_BIT = 1;
   // primary register numbers
   localparam logic [3:0] CTM_CRN_CACHE = 4'h7;
   localparam logic [3:0] CTM_CRN_LOCK = 4'h9;
   localparam logic [3:0] CTM_CRN_TEST = 4'hF;
   // crm codes
   localparam logic [3:0] CTM_CRM_0 = 4'h0;
   localparam logic [3:0] CTM_CRM_1 = 4'h1;
   localparam logic [3:0] CTM_CRM_2 = 4'h2;
   localparam logic [3:0] CTM_CRM_3 = 4'h3;
   localparam logic [3:0] CTM_CRM_I = 4'h5;
   localparam logic [3:0] CTM_CRM_D = 4'h6;
   localparam logic [3:0] CTM_CRM_ID = 4'h7;
   localparam logic [3:0] CTM_CRM_RI = 4'h9;
   localparam logic [3:0] CTM_CRM_RD = 4'hA;
   localparam logic [3:0] CTM_CRM_RID = 4'hB;
   localparam logic [3:0] CTM_CRM_PREF = 4'hD;
   localparam logic [3:0] CTM_CRM_CLINV = 4'hE;
   // opcode1 / opcode2 values
   localparam logic [2:0] CTM_OP1_STD = 3'h0;
   localparam logic [2:0] CTM_OP1_TEST = 3'h2;
   localparam logic [2:0] CTM_OP1_TDR = 3'h3;
   localparam logic [2:0] CTM_OP2_0 = 3'h0;
   localparam logic [2:0] CTM_OP2_1 = 3'h1;
   localparam logic [2:0] CTM_OP2_2 = 3'h2;
   localparam logic [2:0] CTM_OP2_4 = 3'h4;
   localparam logic [2:0] CTM_OP2_MATCH = 3'h5;
   localparam logic [2:0] CTM_OP2_WR = 3'h6;

   typedef struct packed {
      logic wr;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
      logic [31:0] rd;
   } ctm_req_t;

   typedef struct packed {
      logic valid;
      logic [CTM_TAG_W-1:0] tag;
      logic dirty_even;
      logic dirty_odd;
      logic wb;
   } ctm_tag_t;

   typedef enum logic [2:0] {
      CTM_S_IDLE, CTM_S_CLEAN, CTM_S_DRAIN, CTM_S_WFI
   } ctm_state_t;
endpackage

// file: verif/ctm_maint_chk.sv
// port assertions for the cache maintenance decoder
`timescale 1ns/100ps
module ctm_maint_chk
   import ctm_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire ctm_req_t req,
   input wire logic dbg_interp,
   input wire ctm_req_t dbg_req,
   input wire logic dbg_valid,
   input wire logic irq,
   input wire logic clean_done,
   input wire logic busy,
   input wire logic rdata_valid,
   input wire logic undef,
   input wire logic clean_req,
   input wire logic [31:0] clean_addr,
   input wire logic clean_by_index,
   input wire logic prefetch_req,
   input wire logic [31:0] prefetch_addr,
   input wire logic low_power
);
   ctm_req_t q;
   logic tk, c7, w7;
   logic [6:0] cm;
   // requests offered while busy are dropped, so they never count as taken
   assign q = dbg_interp ? dbg_req : req;
   assign tk = !busy && (dbg_interp ? dbg_valid : req_valid);
   assign c7 = tk && q.op1 == CTM_OP1_STD && q.crn == CTM_CRN_CACHE;
   assign w7 = c7 && q.wr;
   assign cm = {q.crm, q.op2};
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_read7_undef:
      assert property (c7 && !q.wr |=> undef && !rdata_valid)
      else $error("register 7 read not refused");
   a_write7_silent:
      assert property (w7 |=> !rdata_valid && !undef)
      else $error("register 7 write gave read data");
   a_prefetch_pulse:
      assert property (w7 && cm == {CTM_CRM_PREF, CTM_OP2_1} |=>
         prefetch_req && prefetch_addr == $past(q.rd) ##1 !prefetch_req)
      else $error("prefetch pulse or address wrong");
   a_clean_start:
      assert property (w7 && (q.crm == CTM_CRM_RD || q.crm == CTM_CRM_CLINV)
         && (q.op2 == CTM_OP2_1 || q.op2 == CTM_OP2_2) |=> clean_req && busy
         && clean_addr == $past(q.rd)
         && clean_by_index == ($past(q.op2) == CTM_OP2_2))
      else $error("clean did not start correctly");
   a_clean_hold:
      assert property (clean_req && !clean_done |=> clean_req && busy)
      else $error("clean ended before done");
   a_clean_end:
      assert property (clean_req && clean_done |=> !clean_req && !busy)
      else $error("clean did not end after done");
   a_drain_busy:
      assert property (w7 && cm == {CTM_CRM_RD, CTM_OP2_4} |=>
         busy && !clean_req)
      else $error("drain did not stall");
   a_wfi_sleep:
      assert property (w7 && cm == {CTM_CRM_0, CTM_OP2_4} |=>
         low_power && busy)
      else $error("wait for interrupt did not sleep");
   a_wfi_stay:
      assert property (!irq [*4] ##0 low_power |=> low_power)
      else $error("woke without interrupt");
   a_tdr_read:
      assert property (tk && !q.wr && q.op1 == CTM_OP1_TDR
         && q.crn == CTM_CRN_TEST && cm == {CTM_CRM_1, 3'h0} |=> rdata_valid)
      else $error("test data read not answered");
   a_busy_drop:
      assert property (busy && (dbg_interp ? dbg_valid : req_valid) |=>
         !rdata_valid && !undef && !prefetch_req)
      else $error("request taken while busy");
   c_clean: cover property (clean_req && clean_done);
   c_wake: cover property (low_power ##1 !low_power);
   c_undef: cover property (c7 && !q.wr);
endmodule
bind ctm_maint ctm_maint_chk chk (.clk(clk), .resetn(resetn),
   .req_valid(req_valid), .req(req), .dbg_interp(dbg_interp),
   .dbg_req(dbg_req), .dbg_valid(dbg_valid), .irq(irq),
   .clean_done(clean_done), .busy(busy), .rdata_valid(rdata_valid),
   .undef(undef), .clean_req(clean_req), .clean_addr(clean_addr),
   .clean_by_index(clean_by_index), .prefetch_req(prefetch_req),
   .prefetch_addr(prefetch_addr), .low_power(low_power));

// file: verif/ctm_mem_side.sv
// far-side model: external clean engine and write buffer level
`timescale 1ns/100ps
module ctm_mem_side (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clean_req,
   input wire logic [3:0] clean_lat,
   input wire logic wb_pend,
   output logic clean_done,
   output logic wb_empty
);
   logic [3:0] cnt_reg;
   // count restarts after each done so a second clean waits in full
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 4'h0;
         clean_done <= 1'b0;
      end else begin
         clean_done <= 1'b0;
         if (!clean_req || clean_done)
            cnt_reg <= 4'h0;
         else if (cnt_reg == clean_lat)
            clean_done <= 1'b1;
         else
            cnt_reg <= cnt_reg + 4'h1;
      end
   end
   assign wb_empty = !wb_pend;
endmodule

// file: verif/tb_top.sv
// self-checking bench for the cache maintenance decoder
`timescale 1ns/100ps
module tb_top;
   import ctm_pkg::*;
   logic clk, resetn, req_valid, dbg_interp, dbg_valid, irq, wb_pend;
   logic wb_empty, clean_done, busy, rdata_valid, undef, clean_req;
   logic clean_by_index, prefetch_req, low_power;
   logic [31:0] rdata, clean_addr, prefetch_addr;
   logic [3:0] clean_lat;
   logic [3:0] crm7 [3] = '{CTM_CRM_ID, CTM_CRM_I, CTM_CRM_D};
   ctm_req_t req, dbg_req;
   int fails, compares, k;
   ctm_maint uut (.clk(clk), .resetn(resetn), .req_valid(req_valid),
      .req(req), .dbg_interp(dbg_interp), .dbg_req(dbg_req),
      .dbg_valid(dbg_valid), .wb_empty(wb_empty), .irq(irq),
      .clean_done(clean_done), .busy(busy), .rdata_valid(rdata_valid),
      .rdata(rdata), .undef(undef), .clean_req(clean_req),
      .clean_addr(clean_addr), .clean_by_index(clean_by_index),
      .prefetch_req(prefetch_req), .prefetch_addr(prefetch_addr),
      .low_power(low_power));
   ctm_mem_side far (.clk(clk), .resetn(resetn), .clean_req(clean_req),
      .clean_lat(clean_lat), .wb_pend(wb_pend), .clean_done(clean_done),
      .wb_empty(wb_empty));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic wrap_up();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one request per call; outputs of the taking edge are sampled on return
   task automatic op(input logic w, input logic [2:0] o1,
      input logic [3:0] n, input logic [3:0] m, input logic [2:0] o2,
      input logic [31:0] d);
      @(negedge clk);
      req = '{wr: w, op1: o1, crn: n, crm: m, op2: o2, rd: d};
      dbg_req = req;
      req_valid = !dbg_interp;
      dbg_valid = dbg_interp;
      @(negedge clk);
      req_valid = 1'b0;
      dbg_valid = 1'b0;
   endtask
   task automatic c7(input logic [3:0] m, input logic [2:0] o2,
      input logic [31:0] d);
      op(1'b1, CTM_OP1_STD, CTM_CRN_CACHE, m, o2, d);
   endtask
   task automatic c9(input logic w, input logic [3:0] m,
      input logic [2:0] o2, input logic [31:0] d);
      op(w, CTM_OP1_STD, CTM_CRN_LOCK, m, o2, d);
   endtask
   task automatic t15(input logic [3:0] m, input logic [2:0] o2,
      input logic [31:0] d);
      op(1'b1, CTM_OP1_TEST, CTM_CRN_TEST, m, o2, d);
   endtask
   task automatic tdw(input logic [3:0] m, input logic [31:0] d);
      op(1'b1, CTM_OP1_TDR, CTM_CRN_TEST, m, CTM_OP2_0, d);
   endtask
   task automatic tdm(input logic [3:0] m, input logic [31:0] mk,
      input logic [31:0] e);
      op(1'b0, CTM_OP1_TDR, CTM_CRN_TEST, m, CTM_OP2_0, 32'h0);
      chk({31'h0, rdata_valid}, 32'h1);
      chk(rdata & mk, e);
   endtask
   task automatic idle(input int lim);
      int i;
      for (i = 0; i < lim && busy !== 1'b0; i++)
         @(negedge clk);
      if (busy !== 1'b0) begin
         fails++;
         wrap_up();
      end
   endtask
   initial begin
      resetn = 1'b0;
      req_valid = 1'b0;
      dbg_valid = 1'b0;
      dbg_interp = 1'b0;
      irq = 1'b0;
      wb_pend = 1'b0;
      clean_lat = 4'h6;
      req = '0;
      dbg_req = '0;
      fails = 0;
      compares = 0;
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      tdm(CTM_CRM_1, 32'hFFFFFFFF, 32'h0);
      tdw(CTM_CRM_1, 32'hA5A51234);
      tdw(CTM_CRM_2, 32'h5A5A0F0F);
      tdm(CTM_CRM_1, 32'hFFFFFFFF, 32'hA5A51234);
      tdm(CTM_CRM_2, 32'hFFFFFFFF, 32'h5A5A0F0F);
      tdw(CTM_CRM_3, 32'hC3C3C3C3);
      tdm(CTM_CRM_1, 32'hFFFFFFFF, 32'hC3C3C3C3);
      tdm(CTM_CRM_2, 32'hFFFFFFFF, 32'hC3C3C3C3);
      $display("test data registers done");
      for (k = 0; k < 3; k++) begin
         op(1'b0, CTM_OP1_STD, CTM_CRN_CACHE, crm7[k], CTM_OP2_0, 32'h0);
         chk({30'h0, undef, rdata_valid}, 32'h2);
      end
      c9(1'b1, CTM_CRM_0, CTM_OP2_0, 32'h44000000);
      c9(1'b1, CTM_CRM_0, CTM_OP2_1, 32'h0C000000);
      c9(1'b0, CTM_CRM_0, CTM_OP2_0, 32'h0);
      chk(rdata, 32'h44000000);
      c9(1'b0, CTM_CRM_0, CTM_OP2_1, 32'h0);
      chk(rdata, 32'h0C000000);
      $display("lockdown done");
      // base write mode: each data access moves the victim on
      tdw(CTM_CRM_2, 32'h11112222);
      t15(CTM_CRM_RD, CTM_OP2_WR, 32'h54);
      tdw(CTM_CRM_2, 32'h33334444);
      t15(CTM_CRM_RD, CTM_OP2_WR, 32'h54);
      c9(1'b1, CTM_CRM_0, CTM_OP2_0, 32'h44000000);
      t15(CTM_CRM_RD, CTM_OP2_2, 32'h54);
      tdm(CTM_CRM_2, 32'hFFFFFFFF, 32'h11112222);
      t15(CTM_CRM_RD, CTM_OP2_2, 32'h54);
      tdm(CTM_CRM_2, 32'hFFFFFFFF, 32'h33334444);
      c9(1'b1, CTM_CRM_1, CTM_OP2_0, 32'h44000040);
      for (k = 0; k < 2; k++) begin
         t15(CTM_CRM_RD, CTM_OP2_2, 32'h54);
         tdm(CTM_CRM_2, 32'hFFFFFFFF, 32'h11112222);
      end
      t15(CTM_CRM_D, CTM_OP2_WR, 32'h00ABCD50);
      c9(1'b1, CTM_CRM_0, CTM_OP2_0, 32'h44000000);
      t15(CTM_CRM_D, CTM_OP2_2, 32'h40);
      tdm(CTM_CRM_2, 32'hFFFFFF10, 32'h00ABCD10);
      t15(CTM_CRM_2, CTM_OP2_0, 32'h0);
      c9(1'b1, CTM_CRM_0, CTM_OP2_0, 32'h44000000);
      t15(CTM_CRM_D, CTM_OP2_2, 32'h40);
      tdm(CTM_CRM_2, 32'hFFFFFF1C, 32'h00ABCD1C);
      c9(1'b1, CTM_CRM_0, CTM_OP2_0, 32'h44000000);
      t15(CTM_CRM_D, CTM_OP2_MATCH, 32'h00ABCD54);
      chk({30'h0, prefetch_req, clean_req}, 32'h0);
      tdm(CTM_CRM_2, 32'hFFFFFFFF, 32'h11112222);
      t15(CTM_CRM_D, CTM_OP2_MATCH, 32'h00ABCE54);
      chk({30'h0, prefetch_req, clean_req}, 32'h0);
      tdm(CTM_CRM_2, 32'hFFFFFFFF, 32'h0);
      c7(CTM_CRM_I, CTM_OP2_0, 32'h0);
      t15(CTM_CRM_D, CTM_OP2_MATCH, 32'h00ABCD54);
      tdm(CTM_CRM_2, 32'hFFFFFFFF, 32'h11112222);
      c7(CTM_CRM_D, CTM_OP2_1, 32'h44000040);
      c7(CTM_CRM_D, CTM_OP2_0, 32'h0);
      t15(CTM_CRM_D, CTM_OP2_MATCH, 32'h00ABCD54);
      tdm(CTM_CRM_2, 32'hFFFFFFFF, 32'h0);
      $display("cache arrays done");
      c7(CTM_CRM_PREF, CTM_OP2_1, 32'h00400020);
      chk({31'h0, prefetch_req}, 32'h1);
      chk(prefetch_addr, 32'h00400020);
      c7(CTM_CRM_RD, CTM_OP2_2, 32'h44000040);
      chk({29'h0, busy, clean_req, clean_by_index}, 32'h7);
      chk(clean_addr, 32'h44000040);
      op(1'b0, CTM_OP1_TDR, CTM_CRN_TEST, CTM_CRM_1, CTM_OP2_0, 32'h0);
      chk({31'h0, rdata_valid}, 32'h0);
      idle(20);
      c7(CTM_CRM_CLINV, CTM_OP2_1, 32'h00ABCD54);
      chk({29'h0, busy, clean_req, clean_by_index}, 32'h6);
      idle(20);
      chk({31'h0, clean_req}, 32'h0);
      $display("clean done");
      wb_pend = 1'b1;
      c7(CTM_CRM_RD, CTM_OP2_4, 32'h0);
      repeat (8) @(negedge clk);
      chk({31'h0, busy}, 32'h1);
      wb_pend = 1'b0;
      idle(10);
      c7(CTM_CRM_0, CTM_OP2_4, 32'h0);
      repeat (8) @(negedge clk);
      chk({31'h0, low_power}, 32'h1);
      irq = 1'b1;
      idle(10);
      chk({31'h0, low_power}, 32'h0);
      irq = 1'b0;
      $display("stall done");
      dbg_interp = 1'b1;
      tdw(CTM_CRM_1, 32'h76543210);
      tdm(CTM_CRM_1, 32'hFFFFFFFF, 32'h76543210);
      dbg_interp = 1'b0;
      $display("interpret done");
      wrap_up();
   end
endmodule
